// ===== dcc_comparator_ctrl.sv
// Register slave and digital control of two analog comparators
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module dcc_comparator_ctrl
  import dcc_pkg::*;
(
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // Analog comparators
  input  wire logic [1:0]      cmp_raw,
  output dcc_cmp_cfg_t [1:0]   cmp_cfg,
  // Port pins
  output logic [1:0]           cmp_pin_o,
  output logic [1:0]           cmp_pin_oe,
  input  wire logic [3:0]      shared_analog_pin_i,
  output logic [3:0]           analog_select_o,
  // Timer
  input  wire dcc_tmr_status_t tmr_i,
  input  wire logic            timer_gate_pin,
  output dcc_tmr_gate_t        tmr_o,
  output logic [1:0]           cmp_change_pulse
);

  dcc_cmp_cfg_t [1:0] cfg_q;
  logic               gate_src_q;
  logic               sync_en_q;
  logic [1:0]         port_dir_q;
  logic [3:0]         analog_q;
  logic [1:0]         raw_s;
  logic [3:0]         pin_s;
  logic               gate_pin_s;
  logic [1:0]         result_q;
  logic [1:0]         mm_latch_q;
  logic [1:0]         mm_prev_q;
  logic [1:0]         pulse_q;
  logic               tclk_prev_q;
  logic               cmp2_latch_q;
  logic               synced_cmp2_result;
  logic               tclk_fall;

  // AXI handshake state
  logic               aw_hold_q;
  logic [7:0]         aw_addr_q;
  logic               w_hold_q;
  logic [31:0]        w_data_q;
  logic [3:0]         w_strb_q;
  logic               aw_fire;
  logic               w_fire;
  logic               wr_go;
  logic [7:0]         wr_addr;
  logic [31:0]        wr_data;
  logic [3:0]         wr_strb;
  logic               rd_fire;
  logic [7:0]         rd_addr_q;
  logic [31:0]        rd_word;
  logic               rd_ok;

  // All asynchronous levels cross in one synchroniser bank
  dcc_sync2 #(
    .WIDTH (7)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .async_i ({timer_gate_pin, shared_analog_pin_i, cmp_raw}),
    .sync_o  ({gate_pin_s, pin_s, raw_s})
  );

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign wr_go         = (aw_hold_q || aw_fire) && (w_hold_q || w_fire) && !s_axi_bvalid;
  assign wr_addr       = aw_hold_q ? aw_addr_q : s_axi_awaddr;
  assign wr_data       = w_hold_q ? w_data_q : s_axi_wdata;
  assign wr_strb       = w_hold_q ? w_strb_q : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      aw_addr_q    <= '0;
      w_hold_q     <= 1'b0;
      w_data_q     <= '0;
      w_strb_q     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCC_RESP_OKAY;
    end else begin
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr == DCC_OFS_CMP1_CTRL || wr_addr == DCC_OFS_CMP2_CTRL ||
                         wr_addr == DCC_OFS_MIRROR_GATE || wr_addr == DCC_OFS_PORT_READ ||
                         wr_addr == DCC_OFS_PIN_CONFIG) ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      end else begin
        if (aw_fire) begin
          aw_hold_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_hold_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Software-written configuration; result bits ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q      <= {DCC_RST_CMP_CFG, DCC_RST_CMP_CFG};
      gate_src_q <= DCC_RST_GATE_SRC;
      sync_en_q  <= DCC_RST_SYNC_EN;
      port_dir_q <= DCC_RST_DIR;
      analog_q   <= DCC_RST_ANALOG;
    end else if (wr_go) begin
      if (wr_strb[0]) begin
        case (wr_addr)
          DCC_OFS_CMP1_CTRL, DCC_OFS_CMP2_CTRL: begin
            cfg_q[wr_addr == DCC_OFS_CMP2_CTRL] <= '{
              enable:         wr_data[DCC_BIT_ENABLE],
              pin_drive:      wr_data[DCC_BIT_PIN_DRIVE],
              invert:         wr_data[DCC_BIT_INVERT],
              ref_select:     wr_data[DCC_BIT_REF_SEL],
              channel_select: wr_data[DCC_CH_LSB +: 2]
            };
          end
          DCC_OFS_MIRROR_GATE: begin
            gate_src_q <= wr_data[DCC_BIT_GATE_SRC];
            sync_en_q  <= wr_data[DCC_BIT_SYNC_EN];
          end
          DCC_OFS_PIN_CONFIG: begin
            port_dir_q <= wr_data[DCC_DIR_LSB +: 2];
          end
          default: begin
          end
        endcase
      end
      if (wr_strb[1] && wr_addr == DCC_OFS_PIN_CONFIG) begin
        analog_q <= wr_data[DCC_ANALOG_LSB +: 4];
      end
    end
  end

  assign cmp_cfg         = cfg_q;
  assign analog_select_o = analog_q;

  // Read channel: answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    case (s_axi_araddr)
      DCC_OFS_CMP1_CTRL, DCC_OFS_CMP2_CTRL: begin
        rd_word[DCC_BIT_ENABLE]    = cfg_q[s_axi_araddr == DCC_OFS_CMP2_CTRL].enable;
        rd_word[DCC_BIT_RESULT]    = result_q[s_axi_araddr == DCC_OFS_CMP2_CTRL];
        rd_word[DCC_BIT_PIN_DRIVE] = cfg_q[s_axi_araddr == DCC_OFS_CMP2_CTRL].pin_drive;
        rd_word[DCC_BIT_INVERT]    = cfg_q[s_axi_araddr == DCC_OFS_CMP2_CTRL].invert;
        rd_word[DCC_BIT_REF_SEL]   = cfg_q[s_axi_araddr == DCC_OFS_CMP2_CTRL].ref_select;
        rd_word[DCC_CH_LSB +: 2]   = cfg_q[s_axi_araddr == DCC_OFS_CMP2_CTRL].channel_select;
      end
      DCC_OFS_MIRROR_GATE: begin
        rd_word[DCC_BIT_MIRROR1]  = result_q[0];
        rd_word[DCC_BIT_MIRROR2]  = result_q[1];
        rd_word[DCC_BIT_GATE_SRC] = gate_src_q;
        rd_word[DCC_BIT_SYNC_EN]  = sync_en_q;
      end
      DCC_OFS_PORT_READ: begin
        rd_word[3:0] = pin_s & ~analog_q;
      end
      DCC_OFS_PIN_CONFIG: begin
        rd_word[DCC_DIR_LSB +: 2]    = port_dir_q;
        rd_word[DCC_ANALOG_LSB +: 4] = analog_q;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= DCC_RESP_OKAY;
      rd_addr_q    <= '0;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? DCC_RESP_OKAY : DCC_RESP_SLVERR;
      rd_addr_q    <= s_axi_araddr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Per-comparator result, mismatch edge and pin path
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    logic ctrl_read;
    assign ctrl_read = rd_fire &&
                       (s_axi_araddr == (i == 0 ? DCC_OFS_CMP1_CTRL : DCC_OFS_CMP2_CTRL));

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        result_q[i]   <= 1'b0;
        mm_latch_q[i] <= 1'b0;
        mm_prev_q[i]  <= 1'b0;
        pulse_q[i]    <= 1'b0;
        cmp_pin_o[i]  <= 1'b0;
        cmp_pin_oe[i] <= 1'b0;
      end else begin
        // A disabled comparator reads as low
        result_q[i]   <= cfg_q[i].enable && (raw_s[i] ^ cfg_q[i].invert);
        // Only reads of the own control register refresh the latch
        if (ctrl_read) begin
          mm_latch_q[i] <= result_q[i];
        end
        mm_prev_q[i]  <= mm_latch_q[i] ^ result_q[i];
        pulse_q[i]    <= (mm_latch_q[i] ^ result_q[i]) && !mm_prev_q[i];
        cmp_pin_o[i]  <= result_q[i];
        cmp_pin_oe[i] <= cfg_q[i].pin_drive && cfg_q[i].enable && !port_dir_q[i];
      end
    end
  end

  assign cmp_change_pulse = pulse_q;

  // Latch on the falling edge of the prescaled timer clock; the timer
  // itself counts on the rising edge, so the gate never races it
  assign tclk_fall = tclk_prev_q && !tmr_i.clk_src;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tclk_prev_q  <= 1'b0;
      cmp2_latch_q <= 1'b0;
    end else begin
      tclk_prev_q <= tmr_i.clk_src;
      if (tclk_fall) begin
        cmp2_latch_q <= result_q[1];
      end
    end
  end

  assign synced_cmp2_result = sync_en_q ? cmp2_latch_q : result_q[1];

  assign tmr_o.gate_level       = gate_src_q ? gate_pin_s : synced_cmp2_result;
  assign tmr_o.gate_from_cmp2   = !gate_src_q;
  assign tmr_o.cmp2_gate_active = !gate_src_q && tmr_i.on && tmr_i.gate_enable;

  // Checks
  property p_result_polarity;
    @(posedge aclk) disable iff (!aresetn)
      $past(cfg_q[0].enable) && $past(aresetn, 3) |->
        result_q[0] == ($past(cmp_raw[0], 3) ^ $past(cfg_q[0].invert));
  endproperty
  a_result_polarity: assert property (p_result_polarity) else $error("result polarity wrong");

  property p_internal_only;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_q[1].pin_drive |=> !cmp_pin_oe[1];
  endproperty
  a_internal_only: assert property (p_internal_only) else $error("pin driven while internal");

  property p_pin_three_cond;
    @(posedge aclk) disable iff (!aresetn)
      cmp_pin_oe[0] |-> $past(cfg_q[0].enable && cfg_q[0].pin_drive && !port_dir_q[0]);
  endproperty
  a_pin_three_cond: assert property (p_pin_three_cond) else $error("pin enable without all terms");

  property p_cfg_write;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && wr_strb[0] && wr_addr == DCC_OFS_CMP2_CTRL |=>
        cmp_cfg[1].ref_select == $past(wr_data[DCC_BIT_REF_SEL]) &&
        cmp_cfg[1].channel_select == $past(wr_data[DCC_CH_LSB +: 2]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("reference or channel not stored");

  property p_disabled_low;
    @(posedge aclk) disable iff (!aresetn)
      !cfg_q[1].enable |=> !result_q[1];
  endproperty
  a_disabled_low: assert property (p_disabled_low) else $error("disabled comparator reads high");

  property p_ctrl_read_result;
    @(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == DCC_OFS_CMP1_CTRL |=>
        s_axi_rvalid && s_axi_rdata[DCC_BIT_RESULT] == $past(result_q[0]);
  endproperty
  a_ctrl_read_result: assert property (p_ctrl_read_result) else $error("control read result wrong");

  property p_gate_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> gate_src_q && !sync_en_q && cfg_q == '0;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("reset values wrong");

  property p_gate_active;
    @(posedge aclk) disable iff (!aresetn)
      tmr_o.cmp2_gate_active |-> tmr_o.gate_level == synced_cmp2_result && !gate_src_q;
  endproperty
  a_gate_active: assert property (p_gate_active) else $error("timer gate source wrong");

  property p_sync_latch;
    @(posedge aclk) disable iff (!aresetn)
      tclk_fall ##1 sync_en_q && !tclk_fall [*2] |->
        synced_cmp2_result == $past(result_q[1], 2);
  endproperty
  a_sync_latch: assert property (p_sync_latch) else $error("sync latch missed falling edge");

  property p_passthrough;
    @(posedge aclk) disable iff (!aresetn)
      !sync_en_q && !gate_src_q |-> tmr_o.gate_level == result_q[1];
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("async path latched");

  property p_mirror_keeps_latch;
    @(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == DCC_OFS_MIRROR_GATE |=> $stable(mm_latch_q);
  endproperty
  a_mirror_keeps_latch: assert property (p_mirror_keeps_latch) else $error("mirror read moved latch");

  property p_port_analog_zero;
    @(posedge aclk) disable iff (!aresetn)
      rd_fire && s_axi_araddr == DCC_OFS_PORT_READ |=> (s_axi_rdata[3:0] & $past(analog_q)) == 4'h0;
  endproperty
  a_port_analog_zero: assert property (p_port_analog_zero) else $error("analog pin read nonzero");

  property p_edge_pulse;
    @(posedge aclk) disable iff (!aresetn)
      cmp_change_pulse[0] |=> !cmp_change_pulse[0];
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("change event held as level");

  c_write_done:  cover property (@(posedge aclk) disable iff (!aresetn) wr_go ##[1:4] s_axi_bvalid && s_axi_bready);
  c_change:      cover property (@(posedge aclk) disable iff (!aresetn) cmp_change_pulse[1]);
  c_gate_synced: cover property (@(posedge aclk) disable iff (!aresetn) tmr_o.cmp2_gate_active && sync_en_q && tclk_fall);

endmodule : dcc_comparator_ctrl

// ===== dcc_pkg.sv
// Shared constants and carrier types for the dual comparator control block
package dcc_pkg;

  // Register byte offsets
  localparam logic [7:0] DCC_OFS_CMP1_CTRL   = 8'h00;
  localparam logic [7:0] DCC_OFS_CMP2_CTRL   = 8'h04;
  localparam logic [7:0] DCC_OFS_MIRROR_GATE = 8'h08;
  localparam logic [7:0] DCC_OFS_PORT_READ   = 8'h0C;
  localparam logic [7:0] DCC_OFS_PIN_CONFIG  = 8'h10;

  // Per-comparator control register fields
  localparam int unsigned DCC_BIT_ENABLE    = 7;
  localparam int unsigned DCC_BIT_RESULT    = 6;
  localparam int unsigned DCC_BIT_PIN_DRIVE = 5;
  localparam int unsigned DCC_BIT_INVERT    = 4;
  localparam int unsigned DCC_BIT_REF_SEL   = 2;
  localparam int unsigned DCC_CH_LSB        = 0;

  // Mirror and gate register fields
  localparam int unsigned DCC_BIT_MIRROR1   = 7;
  localparam int unsigned DCC_BIT_MIRROR2   = 6;
  localparam int unsigned DCC_BIT_GATE_SRC  = 1;
  localparam int unsigned DCC_BIT_SYNC_EN   = 0;

  // Pin configuration register fields
  localparam int unsigned DCC_DIR_LSB       = 0;
  localparam int unsigned DCC_ANALOG_LSB    = 8;

  // Reset values
  localparam logic       DCC_RST_GATE_SRC   = 1'b1;
  localparam logic       DCC_RST_SYNC_EN    = 1'b0;
  localparam logic [1:0] DCC_RST_DIR        = 2'h3;
  localparam logic [3:0] DCC_RST_ANALOG     = 4'hF;

  // AXI responses
  localparam logic [1:0] DCC_RESP_OKAY      = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic       enable;
    logic       pin_drive;
    logic       invert;
    logic       ref_select;
    logic [1:0] channel_select;
  } dcc_cmp_cfg_t;

  localparam dcc_cmp_cfg_t DCC_RST_CMP_CFG = '0;

  // Timer status seen by the block (same clock domain)
  typedef struct packed {
    logic on;
    logic gate_enable;
    logic clk_src;
  } dcc_tmr_status_t;

  // Gate information handed to the timer
  typedef struct packed {
    logic gate_level;
    logic gate_from_cmp2;
    logic cmp2_gate_active;
  } dcc_tmr_gate_t;

endpackage : dcc_pkg

// ===== dcc_sync2.sv
// Two-flop level synchroniser for asynchronous inputs
`timescale 1ns/100ps
module dcc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage is read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule : dcc_sync2

// ===== dcc_analog_model.sv
// Behavioural comparators and timer clock facing the control block
`timescale 1ns/100ps
module dcc_analog_model
  import dcc_pkg::*;
(
  // Clock and control
  input  wire logic               aclk,
  input  wire logic               tmr_run,
  // Analog levels
  input  wire logic [1:0][7:0]    v_pos,
  input  wire logic [1:0][7:0]    v_ref,
  input  wire logic [3:0][7:0]    v_shr,
  // Comparators and timer
  input  wire dcc_cmp_cfg_t [1:0] cmp_cfg,
  output logic [1:0]              cmp_raw,
  output logic                    tmr_clk
);
  logic [1:0] cnt_q;
  logic       junk_q;
  initial begin
    cnt_q   = 2'h0;
    tmr_clk = 1'b0;
    junk_q  = 1'b0;
  end
  // Switched-off comparator gives noise; timer clock still unless run
  always @(posedge aclk) begin
    junk_q <= ~junk_q;
    if (tmr_run) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3) tmr_clk <= ~tmr_clk;
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_raw[i] = cmp_cfg[i].enable
        ? ((cmp_cfg[i].ref_select ? v_ref[i] : v_pos[i])
           > v_shr[cmp_cfg[i].channel_select])
        : junk_q;
    end
  end
endmodule : dcc_analog_model

// ===== dcc_comparator_ctrl_test.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/100ps
module dcc_comparator_ctrl_test import dcc_pkg::*;;
  logic            aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic            awready, wready, bvalid, arready, rvalid, gpin, run, ton, tge, tclk;
  logic [7:0]      awaddr, araddr;
  logic [31:0]     wdata, rdata, d;
  logic [3:0]      wstrb, dpin, asel;
  logic [1:0]      bresp, rresp, raw, pin_o, pin_oe, pulse, r;
  logic [1:0][7:0] vpos, vref;
  logic [3:0][7:0] vshr;
  dcc_cmp_cfg_t [1:0] cfg;
  dcc_tmr_gate_t   tg;
  int              num_errors, cmp_count, npulse, npulse2;

  dcc_comparator_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .cmp_raw(raw), .cmp_cfg(cfg), .cmp_pin_o(pin_o),
    .cmp_pin_oe(pin_oe), .shared_analog_pin_i(dpin), .analog_select_o(asel),
    .tmr_i({ton, tge, tclk}), .timer_gate_pin(gpin), .tmr_o(tg), .cmp_change_pulse(pulse));
  dcc_analog_model ana (.aclk(aclk), .tmr_run(run), .v_pos(vpos), .v_ref(vref), .v_shr(vshr),
    .cmp_cfg(cfg), .cmp_raw(raw), .tmr_clk(tclk));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (pulse[0]) npulse <= npulse + 1;
    if (pulse[1]) npulse2 <= npulse2 + 1;
  end
  // Every scenario together needs well under this many cycles
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("MISMATCH %0t timeout", $time);
    close_out();
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // Ready and valid both sampled at the edge; bready stays high throughout
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e, "read data");
    chk(r, DCC_RESP_OKAY, "read resp");
  endtask : rdc

  task automatic t_reset();
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h2);
    rd(8'h20);
    chk(r, DCC_RESP_SLVERR, "rd resp");
    wr(8'h20, 32'hFF);
    chk(r, DCC_RESP_SLVERR, "wr resp");
    $display("reset test done");
  endtask : t_reset
  task automatic t_pol();
    wr(8'h00, 32'h80);
    cyc(5);
    rdc(8'h00, 32'hC0);
    wr(8'h00, 32'hD0);
    cyc(5);
    rdc(8'h00, 32'h90);
    wr(8'h00, 32'h40);
    cyc(5);
    rdc(8'h00, 32'h0);
    $display("polarity test done");
  endtask : t_pol
  task automatic t_chan();
    logic [3:0][7:0] t;
    logic [1:0]      n;
    for (int k = 0; k < 4; k++) begin
      t = {4{8'h32}};
      t[k] = 8'hC8;
      n = 2'(k + 1);
      vshr <= t;
      vref <= 16'h0000;
      wr(8'h04, 32'h80 | k);
      cyc(5);
      rdc(8'h04, 32'h80 | k);
      wr(8'h04, 32'h80 | n);
      cyc(5);
      rdc(8'h04, 32'hC0 | n);
      vref <= 16'hFA00;
      wr(8'h04, 32'h84 | k);
      cyc(5);
      rdc(8'h04, 32'hC4 | k);
    end
    vshr <= {4{8'h32}};
    $display("channel test done");
  endtask : t_chan
  task automatic t_pin();
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, 32'h0F02 | i[2]);
      wr(8'h00, (32'(i[0]) << 7) | (32'(i[1]) << 5));
      cyc(6);
      chk(pin_oe[0], i[0] & i[1] & ~i[2], "pin enable");
      chk(pin_oe[1], 0, "pin enable 2");
      if (pin_oe[0] === 1'b1) chk(pin_o[0], 1, "pin level");
    end
    $display("pin test done");
  endtask : t_pin
  task automatic t_mirror();
    wr(8'h04, 32'h80);
    cyc(5);
    rdc(8'h08, 32'hC2);
    wr(8'h04, 32'h90);
    cyc(5);
    rdc(8'h08, 32'h82);
    $display("mirror test done");
  endtask : t_mirror
  task automatic t_change();
    int b;
    int b2;
    rd(8'h00);
    rd(8'h04);
    b = npulse;
    b2 = npulse2;
    vpos <= {2{8'h14}};
    cyc(10);
    chk(npulse - b, 1, "pulse");
    chk(npulse2 - b2, 1, "pulse 2");
    rd(8'h08);
    vpos[0] <= 8'h64;
    cyc(10);
    chk(npulse - b, 1, "pulse");
    vpos[0] <= 8'h14;
    cyc(10);
    chk(npulse - b, 2, "pulse");
    vpos[1] <= 8'h64;
    $display("change test done");
  endtask : t_change
  task automatic t_port();
    rdc(8'h0C, 32'h0);
    wr(8'h10, 32'h0503);
    cyc(4);
    rdc(8'h0C, 32'hA);
    chk(asel, 4'h5, "analog select");
    $display("port test done");
  endtask : t_port
  task automatic t_gate();
    chk(tg, 32'h4, "pin gate");
    wr(8'h04, 32'hA0);
    wr(8'h08, 32'h0);
    cyc(5);
    chk(tg, 32'h7, "cmp gate");
    chk(pin_o[1], 1, "pin level 2");
    vpos[1] <= 8'h14;
    cyc(5);
    chk(tg.gate_level, 0, "async gate");
    ton <= 1'b0;
    cyc(2);
    chk(tg.cmp2_gate_active, 0, "timer off");
    ton <= 1'b1;
    tge <= 1'b0;
    cyc(2);
    chk(tg.cmp2_gate_active, 0, "gating off");
    tge <= 1'b1;
    wr(8'h08, 32'h1);
    vpos[1] <= 8'h64;
    cyc(8);
    chk(tg.gate_level, 0, "latched gate");
    run <= 1'b1;
    cyc(20);
    run <= 1'b0;
    cyc(2);
    chk(tg.gate_level, 1, "latched gate");
    $display("gate test done");
  endtask : t_gate
  // Registers other than the port direction bits hold non-reset values here, so this proves their reset path
  task automatic t_rereset();
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h2);
    rdc(8'h10, 32'h0F03);
    chk(asel, 4'hF, "analog select");
    $display("second reset test done");
  endtask : t_rereset

  task automatic close_out();
    $display("mismatches %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    {aresetn, awvalid, wvalid, arvalid, run} = '0;
    {bready, rready, gpin, ton, tge} = '1;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    dpin = 4'hB;
    vpos = {2{8'h64}};
    vref = '0;
    vshr = {4{8'h32}};
    {num_errors, cmp_count, npulse, npulse2} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    t_reset();
    t_pol();
    t_chan();
    t_pin();
    t_mirror();
    t_change();
    t_port();
    t_gate();
    t_rereset();
    close_out();
  end
endmodule : dcc_comparator_ctrl_test
